// ### tb/qdc_encoder_model.sv
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// incremental encoder driving the two phase pins
// ---------------------------------------------------------------
module qdc_encoder_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       stepReq,
  input  wire logic       stepUp,
  input  wire logic       countDir,
  input  wire logic [7:0] holdCycles,
  output logic            phaseA,
  output logic            phaseB,
  output logic            busy
);
  logic [1:0] idx;
  logic [1:0] nextIdx;
  logic [2:0] step;
  logic [7:0] holdCount;

  assign nextIdx = stepUp ? idx + 2'h1 : idx - 2'h1;

  // every level is held holdCycles; a large hold makes a slow encoder
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 2'h0;
      step <= 3'h0;
      holdCount <= 8'h01;
      phaseA <= 1'h0;
      phaseB <= 1'h0;
      busy <= 1'h0;
    end else if (!busy) begin
      if (stepReq) begin
        busy <= 1'h1;
        holdCount <= holdCycles;
        if (countDir) begin
          phaseB <= stepUp;
          step <= 3'h1;
        end else begin
          idx <= nextIdx;
          phaseA <= nextIdx[0] ^ nextIdx[1];
          phaseB <= nextIdx[1];
          step <= 3'h0;
        end
      end
    end else if (holdCount != 8'h01) begin
      holdCount <= holdCount - 8'h01;
    end else begin
      holdCount <= holdCycles;
      step <= step + 3'h1;
      // direction is dropped only after the pulse, so it never races the count edge
      case (step)
        3'h1: phaseA <= 1'h1;
        3'h2: phaseA <= 1'h0;
        3'h3: phaseB <= 1'h0;
        default: busy <= 1'h0;
      endcase
    end
  end
endmodule

`default_nettype wire

// ### tb/quadrature_decoder_control_bench.sv
`timescale 1ns/1ps
`default_nettype none

module quadrature_decoder_control_bench;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  filt;
    logic        up;
    logic [3:0]  n;
    logic [15:0] cnt;
    logic        dir;
    logic        ovf;
  } qdc_row_type;

  // control byte, filter, encoder direction, steps; then count, direction, wrap edge
  qdc_row_type rows [14] = '{
    '{8'h00, 8'h00, 1'h1, 4'h4, 16'h0004, 1'h1, 1'h0},
    '{8'h00, 8'h00, 1'h0, 4'h4, 16'h0000, 1'h0, 1'h0},
    '{8'h00, 8'h00, 1'h0, 4'h4, 16'hFFFC, 1'h0, 1'h0},
    '{8'h00, 8'h00, 1'h1, 4'h4, 16'h0000, 1'h1, 1'h1},
    '{8'h20, 8'h00, 1'h1, 4'h4, 16'hFFFC, 1'h0, 1'h0},
    '{8'h30, 8'h00, 1'h1, 4'h4, 16'h0000, 1'h1, 1'h1},
    '{8'h10, 8'h00, 1'h0, 4'h4, 16'h0004, 1'h1, 1'h1},
    '{8'h08, 8'h00, 1'h1, 4'h2, 16'h0006, 1'h1, 1'h1},
    '{8'h18, 8'h00, 1'h1, 4'h2, 16'h0004, 1'h0, 1'h1},
    '{8'h28, 8'h00, 1'h0, 4'h2, 16'h0002, 1'h0, 1'h1},
    '{8'h88, 8'h01, 1'h1, 4'h2, 16'h0002, 1'h0, 1'h1},
    '{8'h88, 8'h00, 1'h1, 4'h2, 16'h0004, 1'h1, 1'h1},
    '{8'h48, 8'h20, 1'h1, 4'h2, 16'h0002, 1'h0, 1'h1},
    '{8'h08, 8'h20, 1'h1, 4'h2, 16'h0004, 1'h1, 1'h1}
  };

  logic        clock = 1'h0;
  logic        rst_n = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        stepReq = 1'h0;
  logic        stepUp = 1'h0;
  logic        cdMode = 1'h0;
  logic        otherReq = 1'h1;
  logic [7:0]  hold = 8'h02;
  logic [31:0] prdata, rd;
  logic [15:0] countValue;
  logic        pready, pslverr, phaseA, phaseB, busy, grant, active, irq, err;
  int          nErrors = 0;
  int          nTests = 0;

  always #25 clock = ~clock;

  qdc_quad_decoder DUT (
    .clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phaseAIn(phaseA), .phaseBIn(phaseB), .otherModeRequest(otherReq),
    .otherModeGrant(grant), .quadModeActive(active), .countValue(countValue), .irq(irq)
  );

  qdc_encoder_model encoder (
    .clock(clock), .rst_n(rst_n), .stepReq(stepReq), .stepUp(stepUp), .countDir(cdMode),
    .holdCycles(hold), .phaseA(phaseA), .phaseB(phaseB), .busy(busy)
  );

  // ---------------------------------------------------------------
  // bus, encoder and compare tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    // no fixed latency assumed: hold until the slave answers, the watchdog ends a hang
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    nTests++;
    if (rd !== exp) begin
      nErrors++;
      $display("FAIL t=%0t read=%h expected=%h", $time, rd, exp);
    end
  endtask

  task automatic pinchk(input logic [15:0] got, input logic [15:0] exp);
    nTests++;
    if (got !== exp) begin
      nErrors++;
      $display("FAIL t=%0t pin=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic steps(input logic up, input logic [3:0] n);
    repeat (n) begin
      @(posedge clock);
      stepReq <= 1'h1;
      stepUp <= up;
      @(posedge clock);
      stepReq <= 1'h0;
      do begin
        @(posedge clock);
      end while (busy === 1'h1);
    end
  endtask

  // mode changes are made with the decoder off, so a polarity flip is not counted
  task automatic runRow(input qdc_row_type r);
    cdMode <= r.ctrl[3];
    apb(1'h1, qdc_pkg::ADDR_FILTER, {24'h0, r.filt});
    apb(1'h1, qdc_pkg::ADDR_QDCTRL, {24'h0, r.ctrl});
    repeat (6) @(posedge clock);
    apb(1'h1, qdc_pkg::ADDR_QDCTRL, {24'h0, r.ctrl | 8'h01});
    steps(r.up, r.n);
    repeat (8) @(posedge clock);
    rdchk(qdc_pkg::ADDR_COUNT, {16'h0, r.cnt});
    rdchk(qdc_pkg::ADDR_QDCTRL, {24'h0, r.ctrl[7:3], r.dir, r.ovf, 1'h1});
  endtask

  task automatic testDone();
    $display("mismatches=%0d comparisons=%0d", nErrors, nTests);
    if (nErrors == 0 && nTests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'h1;
    rdchk(qdc_pkg::ADDR_QDCTRL, 32'h0);
    rdchk(qdc_pkg::ADDR_FILTER, 32'h0);
    apb(1'h1, qdc_pkg::ADDR_QDCTRL, 32'hFFFFFFFF);
    rdchk(qdc_pkg::ADDR_QDCTRL, 32'h000000F8);
    apb(1'h1, qdc_pkg::ADDR_WPROT, 32'h1);
    apb(1'h1, qdc_pkg::ADDR_QDCTRL, 32'h1);
    rdchk(qdc_pkg::ADDR_QDCTRL, 32'h1);
    @(negedge clock);
    pinchk(active, 16'h1);
    pinchk(grant, 16'h0);
    apb(1'h1, qdc_pkg::ADDR_WPROT, 32'h0);
    apb(1'h1, qdc_pkg::ADDR_QDCTRL, 32'h0);
    rdchk(qdc_pkg::ADDR_QDCTRL, 32'h1);
    apb(1'h1, qdc_pkg::ADDR_WPROT, 32'h1);
    foreach (rows[i]) runRow(rows[i]);
    // decoder off: a slow encoder moves through the phase A filter but the count holds
    apb(1'h1, qdc_pkg::ADDR_FILTER, 32'h1);
    apb(1'h1, qdc_pkg::ADDR_QDCTRL, 32'h88);
    hold <= 8'h28;
    steps(1'h1, 4'h2);
    repeat (8) @(posedge clock);
    @(negedge clock);
    pinchk(countValue, 16'h0004);
    pinchk(grant, 16'h1);
    apb(1'h1, qdc_pkg::ADDR_COUNT, 32'h1234);
    rdchk(qdc_pkg::ADDR_COUNT, 32'h4);
    // overflow flag: sticky, masked, then cleared
    rdchk(qdc_pkg::ADDR_STATUS, 32'h1);
    @(negedge clock);
    pinchk(irq, 16'h0);
    apb(1'h1, qdc_pkg::ADDR_IRQEN, 32'h1);
    @(negedge clock);
    pinchk(irq, 16'h1);
    apb(1'h1, qdc_pkg::ADDR_IRQCLR, 32'h1);
    rdchk(qdc_pkg::ADDR_STATUS, 32'h0);
    @(negedge clock);
    pinchk(irq, 16'h0);
    // narrow count range: the top wrap lands on the initial value
    apb(1'h1, qdc_pkg::ADDR_MOD, 32'h5);
    apb(1'h1, qdc_pkg::ADDR_COUNTER_INITIAL_VALUE, 32'h2);
    rdchk(qdc_pkg::ADDR_MOD, 32'h5);
    rdchk(qdc_pkg::ADDR_COUNTER_INITIAL_VALUE, 32'h2);
    apb(1'h1, qdc_pkg::ADDR_QDCTRL, 32'h89);
    steps(1'h1, 4'h2);
    repeat (8) @(posedge clock);
    rdchk(qdc_pkg::ADDR_COUNT, 32'h2);
    apb(1'h0, 12'hFFC, 32'h0);
    pinchk(err, 16'h1);
    // second reset in mid-run
    @(posedge clock);
    rst_n <= 1'h0;
    repeat (3) @(posedge clock);
    rst_n <= 1'h1;
    rdchk(qdc_pkg::ADDR_QDCTRL, 32'h0);
    rdchk(qdc_pkg::ADDR_COUNT, 32'h0);
    rdchk(qdc_pkg::ADDR_MOD, 32'hFFFF);
    testDone();
  end

  // watchdog well beyond the fewer than 2000 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clock);
    nErrors++;
    testDone();
  end
endmodule

`default_nettype wire

// ### verilog/qdc_pkg.sv
//
// Functional notes
// - phase A filter enable uses channel 0 value; zero value keeps it off
// - phase B filter enable uses channel 1 value; zero value keeps it off
// - phase A invert flips phase A before edge detection
// - phase B invert flips phase B before edge detection
// - scheme select: 0 quadrature A/B, 1 count and direction
// - read-only direction status: 1 counting up, 0 counting down
// - overflow edge status: 1 wrap at top, 0 wrap at bottom
// - decoder mode enable lets the phases steer the counter
// - decoder mode overrides every other timer mode request
// - decoder enable bit writable only while write protect disable is 1
// - control bits 31 to 8 are read-only zero
// - filter register: channel 0 value bits 3-0, channel 1 bits 7-4
`default_nettype none

package qdc_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [11:0] ADDR_FILTER = 12'h078;
  localparam logic [11:0] ADDR_QDCTRL = 12'h080;
  localparam logic [11:0] ADDR_WPROT  = 12'h084;
  localparam logic [11:0] ADDR_COUNTER_INITIAL_VALUE  = 12'h088;
  localparam logic [11:0] ADDR_MOD    = 12'h08C;
  localparam logic [11:0] ADDR_COUNT  = 12'h090;
  localparam logic [11:0] ADDR_STATUS = 12'h094;
  localparam logic [11:0] ADDR_IRQEN  = 12'h098;
  localparam logic [11:0] ADDR_IRQCLR = 12'h09C;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_FLT_A   = 7;
  localparam int BIT_FLT_B   = 6;
  localparam int BIT_INV_A   = 5;
  localparam int BIT_INV_B   = 4;
  localparam int BIT_SCHEME  = 3;
  localparam int BIT_DIR     = 2;
  localparam int BIT_OVFDIR  = 1;
  localparam int BIT_ENABLE  = 0;
  localparam int BIT_WRITE_PROTECT_DISABLE   = 0;
  localparam int BIT_OVF     = 0;
  localparam int CH0_LSB     = 0;
  localparam int CH1_LSB     = 4;

  // ---------------------------------------------------------------
  // widths, reset values and counts
  // ---------------------------------------------------------------
  localparam int          CNT_W      = 16;
  localparam logic [15:0] COUNTER_INITIAL_VALUE_RST  = 16'h0000;
  localparam logic [15:0] MOD_RST    = 16'hFFFF;
  localparam logic [3:0]  FVAL_RST   = 4'h0;
  localparam logic        CTRL_RST   = 1'b0;
  localparam logic        WRITE_PROTECT_DISABLE_RST  = 1'b0;
  localparam logic [5:0]  STABLE_RST = 6'h00;

endpackage

`default_nettype wire

// ### verilog/qdc_quad_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module qdc_quad_decoder (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        phaseAIn,
  input  wire logic        phaseBIn,
  input  wire logic        otherModeRequest,
  output logic             otherModeGrant,
  output logic             quadModeActive,
  output logic [15:0]      countValue,
  output logic             irq
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic        phaseAFilterEnable, next_phaseAFilterEnable;
  logic        phaseBFilterEnable, next_phaseBFilterEnable;
  logic        phaseAInvert,       next_phaseAInvert;
  logic        phaseBInvert,       next_phaseBInvert;
  logic        decodeSchemeSelect, next_decodeSchemeSelect;
  logic        decoderModeEnable,  next_decoderModeEnable;
  logic        writeProtectDisable, next_writeProtectDisable;
  logic        irqEnable,          next_irqEnable;
  logic [3:0]  chan0FilterValue,   next_chan0FilterValue;
  logic [3:0]  chan1FilterValue,   next_chan1FilterValue;
  logic [15:0] counterInitialValue, next_counterInitialValue;
  logic [15:0] counterModulo,      next_counterModulo;
  logic [15:0] count,              next_count;
  logic        countDirectionStatus, next_countDirectionStatus;
  logic        overflowEdgeStatus, next_overflowEdgeStatus;
  logic        counterOverflowFlag, next_counterOverflowFlag;
  logic        prevA,              next_prevA;
  logic        prevB,              next_prevB;
  logic [31:0] next_prdata;
  logic [31:0] readValue;
  logic [31:0] mergedData;
  logic        wrEn;
  logic        rdSetup;
  logic [1:0]  rawPhase;
  logic [1:0]  sync1;
  logic [1:0]  sync2;
  logic [1:0]  phaseFilt;
  logic [1:0]  fltOn;
  logic [5:0]  fltThr [2];
  logic [5:0]  stableCnt [2];
  logic        pa;
  logic        pb;
  logic        aEdge;
  logic        bEdge;
  logic        step;
  logic        stepUp;

  // byte-lane merge, used by the initial value, modulo and irq clear writes
  function automatic logic [31:0] qdcMerge(input logic [31:0] oldVal,
                                           input logic [31:0] wrVal,
                                           input logic [3:0]  strb);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = wrVal[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // apb handshake
  // ---------------------------------------------------------------
  // zero wait state: read data is caught in the setup cycle
  assign pready  = 1'b1;
  assign wrEn    = psel & penable & pwrite;
  assign rdSetup = psel & ~penable & ~pwrite;
  assign pslverr = psel & penable &
                   ~((paddr >= qdc_pkg::ADDR_FILTER && paddr < qdc_pkg::ADDR_QDCTRL &&
                      paddr == qdc_pkg::ADDR_FILTER) ||
                     (paddr >= qdc_pkg::ADDR_QDCTRL && paddr <= qdc_pkg::ADDR_IRQCLR &&
                      paddr[1:0] == 2'b00));

  // ---------------------------------------------------------------
  // pin synchronisers and input filters
  // ---------------------------------------------------------------
  assign rawPhase  = {phaseBIn, phaseAIn};
  assign fltOn[0]  = phaseAFilterEnable & (chan0FilterValue != 4'h0);
  assign fltOn[1]  = phaseBFilterEnable & (chan1FilterValue != 4'h0);
  assign fltThr[0] = {chan0FilterValue, 2'b00};
  assign fltThr[1] = {chan1FilterValue, 2'b00};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gPhase
      logic       next_filt;
      logic [5:0] next_stable;

      // glitch must last four cycles per filter step to pass
      always_comb begin
        next_filt   = phaseFilt[g];
        next_stable = qdc_pkg::STABLE_RST;
        if (!fltOn[g]) begin
          next_filt = sync2[g];
        end else if (sync2[g] != phaseFilt[g]) begin
          if (stableCnt[g] + 6'h01 >= fltThr[g]) begin
            next_filt = sync2[g];
          end else begin
            next_stable = stableCnt[g] + 6'h01;
          end
        end
      end

      // two flops before anything looks at the pin
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          sync1[g]     <= 1'b0;
          sync2[g]     <= 1'b0;
          phaseFilt[g] <= 1'b0;
          stableCnt[g] <= qdc_pkg::STABLE_RST;
        end else begin
          sync1[g]     <= rawPhase[g];
          sync2[g]     <= sync1[g];
          phaseFilt[g] <= next_filt;
          stableCnt[g] <= next_stable;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  assign mergedData = qdcMerge(32'h0000_0000, pwdata, pstrb);

  always_comb begin
    next_phaseAFilterEnable  = phaseAFilterEnable;
    next_phaseBFilterEnable  = phaseBFilterEnable;
    next_phaseAInvert        = phaseAInvert;
    next_phaseBInvert        = phaseBInvert;
    next_decodeSchemeSelect  = decodeSchemeSelect;
    next_decoderModeEnable   = decoderModeEnable;
    next_writeProtectDisable = writeProtectDisable;
    next_irqEnable           = irqEnable;
    next_chan0FilterValue    = chan0FilterValue;
    next_chan1FilterValue    = chan1FilterValue;
    next_counterInitialValue = counterInitialValue;
    next_counterModulo       = counterModulo;
    if (wrEn && pstrb[0]) begin
      if (paddr == qdc_pkg::ADDR_QDCTRL) begin
        next_phaseAFilterEnable = pwdata[qdc_pkg::BIT_FLT_A];
        next_phaseBFilterEnable = pwdata[qdc_pkg::BIT_FLT_B];
        next_phaseAInvert       = pwdata[qdc_pkg::BIT_INV_A];
        next_phaseBInvert       = pwdata[qdc_pkg::BIT_INV_B];
        next_decodeSchemeSelect = pwdata[qdc_pkg::BIT_SCHEME];
        if (writeProtectDisable) begin
          next_decoderModeEnable = pwdata[qdc_pkg::BIT_ENABLE];
        end
      end else if (paddr == qdc_pkg::ADDR_FILTER) begin
        next_chan0FilterValue = pwdata[qdc_pkg::CH0_LSB +: 4];
        next_chan1FilterValue = pwdata[qdc_pkg::CH1_LSB +: 4];
      end else if (paddr == qdc_pkg::ADDR_WPROT) begin
        next_writeProtectDisable = pwdata[qdc_pkg::BIT_WRITE_PROTECT_DISABLE];
      end else if (paddr == qdc_pkg::ADDR_IRQEN) begin
        next_irqEnable = pwdata[qdc_pkg::BIT_OVF];
      end
    end
    if (wrEn) begin
      if (paddr == qdc_pkg::ADDR_COUNTER_INITIAL_VALUE) begin
        next_counterInitialValue = 16'(qdcMerge({16'h0000, counterInitialValue},
                                                pwdata, pstrb));
      end else if (paddr == qdc_pkg::ADDR_MOD) begin
        next_counterModulo = 16'(qdcMerge({16'h0000, counterModulo}, pwdata, pstrb));
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phaseAFilterEnable  <= qdc_pkg::CTRL_RST;
      phaseBFilterEnable  <= qdc_pkg::CTRL_RST;
      phaseAInvert        <= qdc_pkg::CTRL_RST;
      phaseBInvert        <= qdc_pkg::CTRL_RST;
      decodeSchemeSelect  <= qdc_pkg::CTRL_RST;
      decoderModeEnable   <= qdc_pkg::CTRL_RST;
      writeProtectDisable <= qdc_pkg::WRITE_PROTECT_DISABLE_RST;
      irqEnable           <= qdc_pkg::CTRL_RST;
      chan0FilterValue    <= qdc_pkg::FVAL_RST;
      chan1FilterValue    <= qdc_pkg::FVAL_RST;
      counterInitialValue <= qdc_pkg::COUNTER_INITIAL_VALUE_RST;
      counterModulo       <= qdc_pkg::MOD_RST;
    end else begin
      phaseAFilterEnable  <= next_phaseAFilterEnable;
      phaseBFilterEnable  <= next_phaseBFilterEnable;
      phaseAInvert        <= next_phaseAInvert;
      phaseBInvert        <= next_phaseBInvert;
      decodeSchemeSelect  <= next_decodeSchemeSelect;
      decoderModeEnable   <= next_decoderModeEnable;
      writeProtectDisable <= next_writeProtectDisable;
      irqEnable           <= next_irqEnable;
      chan0FilterValue    <= next_chan0FilterValue;
      chan1FilterValue    <= next_chan1FilterValue;
      counterInitialValue <= next_counterInitialValue;
      counterModulo       <= next_counterModulo;
    end
  end

  // ---------------------------------------------------------------
  // decoder and counter
  // ---------------------------------------------------------------
  // phase A and phase B polarity
  assign pa    = phaseFilt[0] ^ phaseAInvert;
  assign pb    = phaseFilt[1] ^ phaseBInvert;
  assign aEdge = pa ^ prevA;
  assign bEdge = pb ^ prevB;

  // in quadrature mode both phases moving at once is a lost step, so it is dropped
  always_comb begin
    step   = 1'b0;
    stepUp = 1'b0;
    if (decoderModeEnable) begin
      if (decodeSchemeSelect) begin
        step   = aEdge & pa;
        stepUp = pb;
      end else begin
        step   = aEdge ^ bEdge;
        stepUp = aEdge ? (pa ^ prevB) : ~(pb ^ prevA);
      end
    end
  end

  always_comb begin
    next_count                = count;
    next_countDirectionStatus = countDirectionStatus;
    next_overflowEdgeStatus   = overflowEdgeStatus;
    next_counterOverflowFlag  = counterOverflowFlag;
    next_prevA                = pa;
    next_prevB                = pb;
    if (wrEn && paddr == qdc_pkg::ADDR_IRQCLR && mergedData[qdc_pkg::BIT_OVF]) begin
      next_counterOverflowFlag = 1'b0;
    end
    if (step) begin
      next_countDirectionStatus = stepUp;
      if (stepUp && count == counterModulo) begin
        next_count               = counterInitialValue;
        next_overflowEdgeStatus  = 1'b1;
        next_counterOverflowFlag = 1'b1;
      end else if (!stepUp && count == counterInitialValue) begin
        next_count               = counterModulo;
        next_overflowEdgeStatus  = 1'b0;
        next_counterOverflowFlag = 1'b1;
      end else begin
        next_count = stepUp ? count + 16'h0001 : count - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count                <= qdc_pkg::COUNTER_INITIAL_VALUE_RST;
      countDirectionStatus <= qdc_pkg::CTRL_RST;
      overflowEdgeStatus   <= qdc_pkg::CTRL_RST;
      counterOverflowFlag  <= qdc_pkg::CTRL_RST;
      prevA                <= 1'b0;
      prevB                <= 1'b0;
    end else begin
      count                <= next_count;
      countDirectionStatus <= next_countDirectionStatus;
      overflowEdgeStatus   <= next_overflowEdgeStatus;
      counterOverflowFlag  <= next_counterOverflowFlag;
      prevA                <= next_prevA;
      prevB                <= next_prevB;
    end
  end

  assign otherModeGrant = otherModeRequest & ~decoderModeEnable;
  assign quadModeActive = decoderModeEnable;
  assign countValue     = count;
  assign irq            = counterOverflowFlag & irqEnable;

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb begin
    readValue = 32'h0000_0000;
    if (paddr == qdc_pkg::ADDR_QDCTRL) begin
      readValue[7:0] = {phaseAFilterEnable, phaseBFilterEnable, phaseAInvert,
                        phaseBInvert, decodeSchemeSelect, countDirectionStatus,
                        overflowEdgeStatus, decoderModeEnable};
    end else if (paddr == qdc_pkg::ADDR_FILTER) begin
      readValue[7:0] = {chan1FilterValue, chan0FilterValue};
    end else if (paddr == qdc_pkg::ADDR_WPROT) begin
      readValue[qdc_pkg::BIT_WRITE_PROTECT_DISABLE] = writeProtectDisable;
    end else if (paddr == qdc_pkg::ADDR_COUNTER_INITIAL_VALUE) begin
      readValue[15:0] = counterInitialValue;
    end else if (paddr == qdc_pkg::ADDR_MOD) begin
      readValue[15:0] = counterModulo;
    end else if (paddr == qdc_pkg::ADDR_COUNT) begin
      readValue[15:0] = count;
    end else if (paddr == qdc_pkg::ADDR_STATUS) begin
      readValue[qdc_pkg::BIT_OVF] = counterOverflowFlag;
    end else if (paddr == qdc_pkg::ADDR_IRQEN) begin
      readValue[qdc_pkg::BIT_OVF] = irqEnable;
    end
  end

  assign next_prdata = rdSetup ? readValue : prdata;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_qdWrite;
    wrEn && pstrb[0] && paddr == qdc_pkg::ADDR_QDCTRL;
  endsequence

  property p_filterOffA;
    @(posedge clock) disable iff (!rst_n) !fltOn[0] |=> phaseFilt[0] == $past(sync2[0]);
  endproperty
  a_filterOffA: assert property (p_filterOffA) else $error("phase A not bypassed");

  property p_filterOffB;
    @(posedge clock) disable iff (!rst_n) !fltOn[1] |=> phaseFilt[1] == $past(sync2[1]);
  endproperty
  a_filterOffB: assert property (p_filterOffB) else $error("phase B not bypassed");

  property p_filterHoldA;
    @(posedge clock) disable iff (!rst_n)
      fltOn[0] && $changed(phaseFilt[0]) |-> $past(stableCnt[0]) + 6'h01 >= $past(fltThr[0]);
  endproperty
  a_filterHoldA: assert property (p_filterHoldA) else $error("phase A passed early");

  property p_cdRise;
    @(posedge clock) disable iff (!rst_n)
      decoderModeEnable && decodeSchemeSelect && $rose(phaseFilt[0] ^ phaseAInvert)
      && $stable(phaseAInvert) |=> $changed(count) && countDirectionStatus == $past(pb);
  endproperty
  a_cdRise: assert property (p_cdRise) else $error("count/dir step missed");

  property p_quadUp;
    @(posedge clock) disable iff (!rst_n)
      decoderModeEnable && !decodeSchemeSelect && aEdge && !bEdge && (pa ^ prevB)
      && count != counterModulo |=> count == $past(count) + 16'h0001 && countDirectionStatus;
  endproperty
  a_quadUp: assert property (p_quadUp) else $error("quadrature up step wrong");

  property p_bothEdges;
    @(posedge clock) disable iff (!rst_n)
      !decodeSchemeSelect && aEdge && bEdge |=> $stable(count);
  endproperty
  a_bothEdges: assert property (p_bothEdges) else $error("double edge counted");

  property p_wrapTop;
    @(posedge clock) disable iff (!rst_n)
      step && stepUp && count == counterModulo
      |=> count == $past(counterInitialValue) && overflowEdgeStatus && counterOverflowFlag;
  endproperty
  a_wrapTop: assert property (p_wrapTop) else $error("top wrap wrong");

  property p_wrapBottom;
    @(posedge clock) disable iff (!rst_n)
      step && !stepUp && count == counterInitialValue
      |=> count == $past(counterModulo) && !overflowEdgeStatus && !countDirectionStatus;
  endproperty
  a_wrapBottom: assert property (p_wrapBottom) else $error("bottom wrap wrong");

  property p_disabledHold;
    @(posedge clock) disable iff (!rst_n) !decoderModeEnable |=> $stable(count);
  endproperty
  a_disabledHold: assert property (p_disabledHold) else $error("counter moved while off");

  property p_protect;
    @(posedge clock) disable iff (!rst_n)
      s_qdWrite and !writeProtectDisable |=> $stable(decoderModeEnable);
  endproperty
  a_protect: assert property (p_protect) else $error("protected enable changed");

  property p_grant;
    @(posedge clock) disable iff (!rst_n) decoderModeEnable |-> !otherModeGrant;
  endproperty
  a_grant: assert property (p_grant) else $error("other mode granted");

  property p_reservedZero;
    @(posedge clock) disable iff (!rst_n)
      rdSetup && paddr == qdc_pkg::ADDR_QDCTRL |=> prdata[31:8] == 24'h000000;
  endproperty
  a_reservedZero: assert property (p_reservedZero) else $error("reserved bits set");

endmodule

`default_nettype wire
